// ---- design/srdc_pkg.sv ----
// shared constants, types and field layout of the channel control block
package srdc_pkg;
  // register pointer values (control side)
  localparam logic [3:0] PTR_CMD     = 4'h0;
  localparam logic [3:0] PTR_IRQ_CTL = 4'h1;
  localparam logic [3:0] PTR_VEC     = 4'h2;
  localparam logic [3:0] PTR_RXPAR   = 4'h3;
  // read pointers: ext status, condition status, vector, data holding
  localparam logic [3:0] PTR_STAT    = 4'h0;
  localparam logic [3:0] PTR_COND    = 4'h1;
  localparam logic [3:0] PTR_MODVEC  = 4'h2;
  localparam logic [3:0] PTR_RXDATA  = 4'h8;
  // command codes in bits 5:3 of the command register
  localparam logic [2:0] CMD_PT_HIGH = 3'h1;
  localparam logic [2:0] CMD_RST_EXT = 3'h2;
  localparam logic [2:0] CMD_NEXT_RX = 3'h4;
  localparam logic [2:0] CMD_RST_TXP = 3'h5;
  localparam logic [2:0] CMD_ERR_RST = 3'h6;
  // irq_and_transfer_mode_ctrl bit positions
  localparam int B_WREQ_EN = 7;
  localparam int B_REQ_FN  = 6;
  localparam int B_ON_RX   = 5;
  localparam int F_RXIM    = 3;
  localparam int B_PAR_SPC = 2;
  localparam int B_TX_IE   = 1;
  localparam int B_EXT_IE  = 0;
  // receiver_parameter_ctrl bit positions
  localparam int F_BITS    = 6;
  localparam int B_AUTO    = 5;
  localparam int B_HUNT    = 4;
  localparam int B_CRC     = 3;
  localparam int B_RX_EN   = 0;
  // values after reset
  localparam logic [7:0] RST_IRQ_CTL = 8'h00;
  localparam logic [7:0] RST_VEC     = 8'h00;
  localparam logic [7:0] RST_RXPAR   = 8'h00;
  localparam logic [3:0] RST_BITS    = 4'h5;
  // status codes folded into the vector
  localparam logic [2:0] VC_TX   = 3'h0;
  localparam logic [2:0] VC_EXT  = 3'h1;
  localparam logic [2:0] VC_RX   = 3'h2;
  localparam logic [2:0] VC_SPC  = 3'h3;
  localparam logic [2:0] VC_NONE = 3'h7;
  // receive interrupt modes
  typedef enum logic [1:0] {
    RXIM_OFF   = 2'h0,
    RXIM_FIRST = 2'h1,
    RXIM_ALL   = 2'h2,
    RXIM_SPC   = 2'h3
  } srdc_rxim_t;
  // received character with its condition flags
  typedef struct packed {
    logic       eof;
    logic       frm;
    logic       ovr;
    logic       par;
    logic [7:0] data;
  } srdc_rxw_t;
endpackage : srdc_pkg

// ---- design/srdc_top.sv ----
// channel control: wait/request pin, rx/tx/ext interrupts, receiver parameters
// How it works
// - function select 1 drives request low when ready
// - function select 0 floats pin, low on early access
// - bit 5 picks receive or transmit buffer state
// - request on ready held off while the chip is selected
// - request pulses low one cycle after CRC end
// - wait on empty receive read or full transmit write
// - two-bit receive interrupt mode picks four behaviours
// - disabled receive interrupts still modify vector status
// - stripped sync characters never raise receive interrupts
// - overrun, framing, end of frame, parity are special
// - first-char special pending survives channel reset or disable while an errored character heads the buffer
// - next-character command re-arms first-character interrupt
// - every-character mode latches overrun and parity, no hold
// - special-only mode holds errored character until reset
// - parity mismatch special only when both bits enabled
// - transmit interrupt each time buffer becomes empty
// - bit 0 masters external status interrupts, reset clears
// - single vector register, optionally carrying status code
// - bits-per-character encoding, unused bits read one
// - auto enables gate tx by CTS, rx by carrier
// - hunt mode entry sources and clear on match
// - receive CRC enable drives receiver CRC start
// - enable bit 7 clear holds pin in inactive state
// - error reset clears latched errors, releases held data
`timescale 1ns/100ps
module srdc_top
  import srdc_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RSTN,
  input  wire logic       CHAN_RESET,
  input  wire logic       BUS_SEL,
  input  wire logic       BUS_RD,
  input  wire logic       BUS_WR,
  input  wire logic       BUS_DATA_SEL,
  input  wire logic [7:0] BUS_WDATA,
  output logic      [7:0] BUS_RDATA,
  output logic            WREQ_O,
  output logic            WREQ_OE,
  input  wire srdc_rxw_t  RX_WORD,
  input  wire logic       RX_VALID,
  input  wire logic       RX_SYNC_STRIP,
  output logic            RX_READY,
  input  wire logic       TX_BUF_EMPTY,
  input  wire logic       TX_CRC_DONE,
  input  wire logic       TX_ENABLE_BIT,
  input  wire logic       SYNC_MODE,
  input  wire logic       ASYNC_MODE,
  input  wire logic       PARITY_EN,
  input  wire logic       LOCAL_LOOP,
  input  wire logic       AUTO_ECHO,
  input  wire logic       RX_ABORT,
  input  wire logic       RX_SYNC_MATCH,
  input  wire logic [6:0] EXT_EVENT,
  input  wire logic       VEC_CARRIES_STATUS,
  input  wire logic       VEC_STATUS_HIGH,
  input  wire logic       CARRIER_DETECT_INPUT_N,
  input  wire logic       CLEAR_TO_SEND_N,
  output logic            RX_IRQ,
  output logic            TX_IRQ,
  output logic            EXT_IRQ,
  output logic      [3:0] RX_CHAR_BITS,
  output logic            RX_ENABLE,
  output logic            TX_ENABLE,
  output logic            HUNT,
  output logic            RX_CRC_EN
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // decoded character length
  function automatic logic [3:0] char_bits(input logic [1:0] f);
    case (f)
      2'h0:    char_bits = 4'h5;
      2'h1:    char_bits = 4'h7;
      2'h2:    char_bits = 4'h6;
      default: char_bits = 4'h8;
    endcase
  endfunction : char_bits

  // mask of the bits that carry data for a given length
  function automatic logic [7:0] char_mask(input logic [1:0] f);
    case (f)
      2'h0:    char_mask = 8'h1F;
      2'h1:    char_mask = 8'h7F;
      2'h2:    char_mask = 8'h3F;
      default: char_mask = 8'hFF;
    endcase
  endfunction : char_mask

  // pointer advance with wrap
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : next_ptr

  logic [7:0]    ctl_r;
  logic [7:0]    vec_r;
  logic [7:0]    rxpar_r;
  logic [3:0]    ptr_r;
  logic [7:0]    rdata_r;
  srdc_rxw_t     mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          ready_r;
  logic          par_l_r;
  logic          ovr_l_r;
  logic          spc_pend_r;
  logic          armed_r;
  logic          first_pend_r;
  logic          rx_irq_r;
  logic          tx_empty_d_r;
  logic          tx_pend_r;
  logic          ext_pend_r;
  logic          ext_irq_r;
  logic          hunt_r;
  logic          post_rst_r;
  logic          dcd_m_r;
  logic          dcd_s_r;
  logic          cts_m_r;
  logic          cts_s_r;
  logic          rx_en_r;
  logic          tx_en_r;
  logic [3:0]    bits_r;
  logic          wreq_o_r;
  logic          wreq_oe_r;

  // control field decode
  srdc_rxim_t rxim;
  wire wreq_en = ctl_r[B_WREQ_EN];
  wire req_fn  = ctl_r[B_REQ_FN];
  wire on_rx   = ctl_r[B_ON_RX];
  wire par_spc = ctl_r[B_PAR_SPC];
  wire tx_ie   = ctl_r[B_TX_IE];
  wire ext_ie  = ctl_r[B_EXT_IE];
  assign rxim = srdc_rxim_t'(ctl_r[F_RXIM+:2]);

  // special receive condition of one character
  function automatic logic is_spc(input srdc_rxw_t w, input logic ps, input logic pe);
    is_spc = w.ovr | w.frm | w.eof | (w.par & ps & pe);
  endfunction : is_spc

  // buffer head and hold state
  srdc_rxw_t head;
  assign head = mem_r[rp_r];
  wire nonempty = (cnt_r != '0);
  wire head_spc = nonempty & is_spc(head, par_spc, PARITY_EN);
  // every-character mode never holds errored data
  wire hold     = head_spc & (rxim == RXIM_FIRST | rxim == RXIM_SPC);
  wire rx_rdy   = nonempty & ~hold;
  wire wait_on  = wreq_en & ~req_fn;

  // bus decode: data accesses may be stalled by the wait function
  wire data_rd  = BUS_SEL & BUS_DATA_SEL & BUS_RD;
  wire data_wr  = BUS_SEL & BUS_DATA_SEL & BUS_WR;
  wire stall_rx = wait_on & on_rx & data_rd & ~rx_rdy;
  wire stall_tx = wait_on & ~on_rx & data_wr & ~TX_BUF_EMPTY;
  wire stall    = stall_rx | stall_tx;
  wire rd_take  = data_rd & ~stall_rx;
  wire ctl_acc  = BUS_SEL & ~BUS_DATA_SEL & (BUS_RD | BUS_WR);
  wire ctl_wr   = ctl_acc & BUS_WR;
  wire ctl_rd   = ctl_acc & BUS_RD & ~BUS_WR;
  wire we_cmd   = ctl_wr & (ptr_r == PTR_CMD);
  wire we_ctl   = ctl_wr & (ptr_r == PTR_IRQ_CTL);
  wire we_vec   = ctl_wr & (ptr_r == PTR_VEC);
  wire we_rxpar = ctl_wr & (ptr_r == PTR_RXPAR);
  wire [2:0] cmd = BUS_WDATA[5:3];
  wire cmd_err  = we_cmd & (cmd == CMD_ERR_RST);
  wire cmd_next = we_cmd & (cmd == CMD_NEXT_RX);
  wire cmd_txp  = we_cmd & (cmd == CMD_RST_TXP);
  wire cmd_ext  = we_cmd & (cmd == CMD_RST_EXT);

  // pointer returns to zero after any access through it, except a command write, which loads it
  wire [3:0] ptr_nxt = (we_cmd) ? {cmd == CMD_PT_HIGH, BUS_WDATA[2:0]} :
                       (ctl_acc) ? PTR_CMD : ptr_r;

  // buffer push and pop; sync characters to strip are dropped here
  wire push     = RX_VALID & ~RX_SYNC_STRIP & ready_r;
  wire pop_rd   = rd_take & rx_rdy;
  wire pop_err  = cmd_err & hold;
  wire pop      = pop_rd | pop_err;
  wire [CW-1:0] cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  srdc_rxw_t in_w;
  // unused high data bits are forced to one on the way in
  assign in_w = '{eof: RX_WORD.eof, frm: RX_WORD.frm, ovr: RX_WORD.ovr, par: RX_WORD.par,
                  data: RX_WORD.data | ~char_mask(rxpar_r[F_BITS+:2])};
  wire in_spc = push & is_spc(RX_WORD, par_spc, PARITY_EN);

  // ctl write with mode 00 counts as disabling receive interrupts
  wire rx_dis = we_ctl & (BUS_WDATA[F_RXIM+:2] == RXIM_OFF);
  // a head released by error reset must not re-arm the pending flag
  wire spc_pend_nxt = in_spc | (head_spc & ~pop_err) |
                      (spc_pend_r & ~cmd_err & ~rx_dis & ~CHAN_RESET);
  wire first_set    = armed_r & (rxim == RXIM_FIRST) & nonempty;
  wire rx_irq_nxt   = (rxim != RXIM_OFF) & (spc_pend_r | (rxim == RXIM_FIRST & first_pend_r) |
                                            (rxim == RXIM_ALL & nonempty));

  // interrupt vector with optional status code
  wire [2:0] vcode = spc_pend_r ? VC_SPC : nonempty ? VC_RX : tx_pend_r ? VC_TX :
                     ext_pend_r ? VC_EXT : VC_NONE;
  wire [7:0] mod_vec = ~VEC_CARRIES_STATUS ? vec_r :
                       VEC_STATUS_HIGH ? {vec_r[7], vcode, vec_r[3:0]} :
                       {vec_r[7:4], vcode, vec_r[0]};
  wire [7:0] rr_stat = {2'h0, ~cts_s_r, hunt_r, ~dcd_s_r, TX_BUF_EMPTY, 1'b0, nonempty};
  wire [7:0] rr_cond = {head.eof & nonempty, head.frm & nonempty, ovr_l_r, par_l_r, 4'h0};
  wire [7:0] rd_mux  = (ptr_r == PTR_STAT)   ? rr_stat :
                       (ptr_r == PTR_COND)   ? rr_cond :
                       (ptr_r == PTR_MODVEC) ? mod_vec :
                       (ptr_r == PTR_RXDATA) ? head.data : 8'h00;
  wire [7:0] rdata_nxt = rd_take ? head.data : ctl_rd ? rd_mux : rdata_r;

  // wait/request pin
  wire rdy       = on_rx ? rx_rdy : TX_BUF_EMPTY;
  wire crc_pulse = TX_CRC_DONE & ~on_rx & SYNC_MODE & req_fn & wreq_en;
  // request on ready only asserts outside a bus cycle; the CRC pulse can assert inside one
  wire req_low   = wreq_en & ((rdy & ~BUS_SEL) | crc_pulse);
  wire wo_nxt    = req_fn ? ~req_low : 1'b0;
  wire woe_nxt   = req_fn ? 1'b1 : stall;

  // auto enables; the status inputs pass through the synchronisers
  wire rx_en_nxt = rxpar_r[B_RX_EN] & (~rxpar_r[B_AUTO] | ~dcd_s_r | LOCAL_LOOP);
  wire tx_en_nxt = TX_ENABLE_BIT & (~rxpar_r[B_AUTO] | ~cts_s_r | AUTO_ECHO | LOCAL_LOOP);

  // hunt: reset, abort, receiver disable or explicit entry; match leaves
  wire rx_off   = (we_rxpar & rxpar_r[B_RX_EN] & ~BUS_WDATA[B_RX_EN]) | CHAN_RESET;
  wire hunt_set = (we_rxpar & BUS_WDATA[B_HUNT]) | RX_ABORT | rx_off | (post_rst_r & ~ASYNC_MODE);
  wire hunt_nxt = hunt_set | (hunt_r & ~RX_SYNC_MATCH);
  wire ext_set  = (|EXT_EVENT) | (hunt_r & RX_SYNC_MATCH);

  // configuration registers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_r   <= RST_IRQ_CTL;
      vec_r   <= RST_VEC;
      rxpar_r <= RST_RXPAR;
      ptr_r   <= PTR_CMD;
    end else begin
      ptr_r <= ptr_nxt;
      if (we_ctl) begin
        ctl_r <= BUS_WDATA;
      end else if (CHAN_RESET) begin
        ctl_r[B_EXT_IE] <= 1'b0;
      end
      if (we_vec) begin
        vec_r <= BUS_WDATA;
      end
      if (we_rxpar) begin
        rxpar_r <= BUS_WDATA;
      end else if (CHAN_RESET) begin
        rxpar_r[B_RX_EN] <= 1'b0;
      end
    end
  end

  // receive buffer storage
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      ready_r <= 1'b1;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_w;
        wp_r        <= next_ptr(wp_r);
      end
      if (pop) begin
        rp_r <= next_ptr(rp_r);
      end
      cnt_r   <= cnt_nxt;
      ready_r <= (cnt_nxt != CW'(DEPTH));
    end
  end

  // receive condition latches; a new error wins over error reset
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      par_l_r      <= 1'b0;
      ovr_l_r      <= 1'b0;
      spc_pend_r   <= 1'b0;
      armed_r      <= 1'b1;
      first_pend_r <= 1'b0;
      rx_irq_r     <= 1'b0;
    end else begin
      par_l_r      <= (push & RX_WORD.par) | (par_l_r & ~cmd_err);
      ovr_l_r      <= (push & RX_WORD.ovr) | (ovr_l_r & ~cmd_err);
      spc_pend_r   <= spc_pend_nxt;
      armed_r      <= cmd_next | (armed_r & ~first_set);
      first_pend_r <= first_set | (first_pend_r & ~pop_rd & (rxim == RXIM_FIRST));
      rx_irq_r     <= rx_irq_nxt;
    end
  end

  // transmit and external/status interrupts
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_empty_d_r <= 1'b0;
      tx_pend_r    <= 1'b0;
      ext_pend_r   <= 1'b0;
      ext_irq_r    <= 1'b0;
    end else begin
      tx_empty_d_r <= TX_BUF_EMPTY;
      tx_pend_r    <= (tx_ie & TX_BUF_EMPTY & ~tx_empty_d_r) |
                      (tx_pend_r & TX_BUF_EMPTY & ~cmd_txp);
      ext_pend_r   <= ext_set | (ext_pend_r & ~cmd_ext);
      ext_irq_r    <= ext_ie & (ext_set | (ext_pend_r & ~cmd_ext)) & ~CHAN_RESET;
    end
  end

  // pin synchronisers, receiver controls and the wait/request pin
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dcd_m_r    <= 1'b1;
      dcd_s_r    <= 1'b1;
      cts_m_r    <= 1'b1;
      cts_s_r    <= 1'b1;
      rx_en_r    <= 1'b0;
      tx_en_r    <= 1'b0;
      hunt_r     <= 1'b0;
      post_rst_r <= 1'b1;
      bits_r     <= RST_BITS;
      wreq_o_r   <= 1'b0;
      wreq_oe_r  <= 1'b0;
      rdata_r    <= 8'h00;
    end else begin
      dcd_m_r    <= CARRIER_DETECT_INPUT_N;
      dcd_s_r    <= dcd_m_r;
      cts_m_r    <= CLEAR_TO_SEND_N;
      cts_s_r    <= cts_m_r;
      rx_en_r    <= rx_en_nxt;
      tx_en_r    <= tx_en_nxt;
      hunt_r     <= hunt_nxt;
      post_rst_r <= 1'b0;
      bits_r     <= char_bits(rxpar_r[F_BITS+:2]);
      wreq_o_r   <= wo_nxt;
      wreq_oe_r  <= woe_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign BUS_RDATA    = rdata_r;
  assign WREQ_O       = wreq_o_r;
  assign WREQ_OE      = wreq_oe_r;
  assign RX_READY     = ready_r;
  assign RX_IRQ       = rx_irq_r;
  assign TX_IRQ       = tx_pend_r;
  assign EXT_IRQ      = ext_irq_r;
  assign RX_CHAR_BITS = bits_r;
  assign RX_ENABLE    = rx_en_r;
  assign TX_ENABLE    = tx_en_r;
  assign HUNT         = hunt_r;
  assign RX_CRC_EN    = rxpar_r[B_CRC];

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  property p_req_low;
    (wreq_en & req_fn & rdy & ~BUS_SEL) |=> (WREQ_OE && !WREQ_O);
  endproperty
  a_req_low: assert property (p_req_low)
    else $error("request not driven low when ready");

  property p_wait_stall;
    (wait_on & stall) |=> (WREQ_OE && !WREQ_O) ##1 (WREQ_OE == $past(stall));
  endproperty
  a_wait_stall: assert property (p_wait_stall)
    else $error("wait not shown on early access");

  property p_sel_hold;
    (req_fn & BUS_SEL & ~crc_pulse) |=> WREQ_O;
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("request asserted during a bus cycle");

  property p_crc_pulse;
    crc_pulse |=> (!WREQ_O && WREQ_OE);
  endproperty
  a_crc_pulse: assert property (p_crc_pulse)
    else $error("no request pulse at crc end");

  property p_inactive;
    !wreq_en |=> ($past(req_fn) ? (WREQ_O && WREQ_OE) : !WREQ_OE);
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("pin not inactive while disabled");

  property p_wait_float;
    (!req_fn & !stall) |=> !WREQ_OE;
  endproperty
  a_wait_float: assert property (p_wait_float)
    else $error("wait pin driven without stall");

  property p_hold;
    (hold & !cmd_err) |=> (rp_r == $past(rp_r));
  endproperty
  a_hold: assert property (p_hold)
    else $error("held errored character left the buffer");

  property p_err_release;
    (cmd_err & hold) |=> (rp_r != $past(rp_r)) && !ovr_l_r == !$past(push & RX_WORD.ovr);
  endproperty
  a_err_release: assert property (p_err_release)
    else $error("error reset did not release held data");

  property p_rx_off;
    (rxim == RXIM_OFF) [*2] |-> !RX_IRQ;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receive interrupt while disabled");

  property p_tx_irq;
    (tx_ie & TX_BUF_EMPTY & !tx_empty_d_r) |=> TX_IRQ;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("no transmit interrupt on empty");

  property p_ext_mask;
    (!ext_ie || CHAN_RESET) |=> !EXT_IRQ;
  endproperty
  a_ext_mask: assert property (p_ext_mask)
    else $error("external interrupt while masked");

  property p_hunt;
    RX_ABORT |=> HUNT;
  endproperty
  a_hunt: assert property (p_hunt)
    else $error("abort did not enter hunt");

  c_first: cover property ((rxim == RXIM_FIRST) & first_set ##1 RX_IRQ);
  c_hold: cover property (hold ##[1:20] pop_err);
  c_crc: cover property (crc_pulse);
  c_stall: cover property (stall [*3] ##1 rd_take);
endmodule : srdc_top

// ---- tb/srdc_rx_feed.sv ----
// far-side receiver model: offers one character at a time
`timescale 1ns/100ps
module srdc_rx_feed
  import srdc_pkg::*;
(
  input  wire logic      SYS_CLK,
  input  wire logic      RSTN,
  input  wire logic      snd,
  input  wire srdc_rxw_t snd_w,
  input  wire logic      rx_ready,
  output srdc_rxw_t      rx_word,
  output logic           rx_valid
);
  // hold the offer until taken; stale word inverted so it never passes as fresh data
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_valid <= 1'b0;
      rx_word  <= '0;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_word  <= ~rx_word;
    end else if (snd && !rx_valid) begin
      rx_valid <= 1'b1;
      rx_word  <= snd_w;
    end
  end
endmodule : srdc_rx_feed

// ---- tb/srdc_top_bench.sv ----
// self-checking bench for the channel control block
`timescale 1ns/100ps
module srdc_top_bench
  import srdc_pkg::*;
;
  logic       clk = 1'b0, rstn = 1'b0, crst = 1'b0, sel = 1'b0, rd = 1'b0, wr = 1'b0, dsel = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat;
  logic       wo, woe, rrdy, rirq, tirq, eirq, rxen, txen, hunt, crc, rv;
  logic [3:0] nbits;
  srdc_rxw_t  rw;
  srdc_rxw_t  sw = '0;
  logic       sv = 1'b0, strip = 1'b0, txe = 1'b0, crcd = 1'b0, syncm = 1'b0, vector_carries_status = 1'b0, vsh = 1'b0;
  logic       txenb = 1'b0, cdn = 1'b0, ctsn = 1'b0, abrt = 1'b0, smatch = 1'b0, pen = 1'b0;
  logic [6:0] ev = 7'h00;
  int         error_cnt = 0;
  int         n_checks = 0;
  logic [3:0] lens [4] = '{4'h5, 4'h7, 4'h6, 4'h8};

  // 250 MHz clock
  always #2 clk = ~clk;

  srdc_top #(.DEPTH(2)) u_dut (
    .SYS_CLK(clk), .RSTN(rstn), .CHAN_RESET(crst), .BUS_SEL(sel), .BUS_RD(rd), .BUS_WR(wr),
    .BUS_DATA_SEL(dsel), .BUS_WDATA(wd), .BUS_RDATA(rdat), .WREQ_O(wo), .WREQ_OE(woe),
    .RX_WORD(rw), .RX_VALID(rv), .RX_SYNC_STRIP(strip), .RX_READY(rrdy), .TX_BUF_EMPTY(txe),
    .TX_CRC_DONE(crcd), .TX_ENABLE_BIT(txenb), .SYNC_MODE(syncm), .ASYNC_MODE(1'b0),
    .PARITY_EN(pen), .LOCAL_LOOP(1'b0), .AUTO_ECHO(1'b0), .RX_ABORT(abrt), .RX_SYNC_MATCH(smatch),
    .EXT_EVENT(ev), .VEC_CARRIES_STATUS(vector_carries_status), .VEC_STATUS_HIGH(vsh), .CARRIER_DETECT_INPUT_N(cdn),
    .CLEAR_TO_SEND_N(ctsn), .RX_IRQ(rirq), .TX_IRQ(tirq), .EXT_IRQ(eirq), .RX_CHAR_BITS(nbits),
    .RX_ENABLE(rxen), .TX_ENABLE(txen), .HUNT(hunt), .RX_CRC_EN(crc)
  );

  srdc_rx_feed u_feed (
    .SYS_CLK(clk), .RSTN(rstn), .snd(sv), .snd_w(sw), .rx_ready(rrdy), .rx_word(rw), .rx_valid(rv)
  );

  // all drive changes land 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // one bus access, strobe held for exactly one sampling edge
  task automatic acc(input logic r, input logic d, input logic [7:0] v);
    {sel, rd, wr, dsel, wd} = {1'b1, r, !r, d, v};
    tick(1);
    {sel, rd, wr, dsel} = 4'h0;
    tick(1);
  endtask : acc

  task automatic wreg(input logic [2:0] p, input logic [7:0] v);
    acc(1'b0, 1'b0, {5'h00, p});
    acc(1'b0, 1'b0, v);
  endtask : wreg

  task automatic rreg(input logic [2:0] p);
    acc(1'b0, 1'b0, {5'h00, p});
    acc(1'b1, 1'b0, 8'h00);
  endtask : rreg

  task automatic snd(input srdc_rxw_t w);
    sw = w;
    sv = 1'b1;
    tick(1);
    sv = 1'b0;
    tick(3);
  endtask : snd

  // stalled data access held until the condition clears, then taken
  task automatic stall(input logic r);
    {sel, rd, wr, dsel} = {1'b1, r, !r, 1'b1};
    sw = 12'h0C3;
    tick(3);
    chk1(wo, 1'b0);
    chk1(woe, 1'b1);
    // release: a character arrives, or the transmit buffer drains
    sv  = r;
    txe = !r;
    tick(1);
    sv = 1'b0;
    if (r) begin
      tick(2);
    end
    {sel, rd, wr, dsel} = 4'h0;
    txe = 1'b0;
    tick(2);
    chk1(woe, 1'b0);
  endtask : stall

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #40000;
    error_cnt++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    tick(16);
    rstn = 1'b1;
    tick(2);
    chk({4'h0, nbits}, {4'h0, RST_BITS});
    chk1(woe, 1'b0);
    chk1(rrdy, 1'b1);
    tend("reset");
    for (int i = 0; i < 4; i++) begin
      wreg(3'h3, {i[1:0], 6'h19});
      tick(1);
      chk({4'h0, nbits}, {4'h0, lens[i]});
    end
    chk1(crc, 1'b1);
    chk1(hunt, 1'b1);
    chk1(rxen, 1'b1);
    cdn = 1'b1;
    ctsn = 1'b1;
    txenb = 1'b1;
    wreg(3'h3, 8'hE1);
    tick(2);
    chk1(rxen, 1'b0);
    chk1(txen, 1'b0);
    {cdn, ctsn} = 2'b00;
    tick(4);
    chk1(rxen, 1'b1);
    chk1(txen, 1'b1);
    tend("rx params");
    wreg(3'h1, 8'h10);
    snd({4'h0, 8'hA5});
    chk1(rirq, 1'b1);
    acc(1'b1, 1'b1, 8'h00);
    chk(rdat, 8'hA5);
    strip = 1'b1;
    snd({4'h0, 8'h3C});
    strip = 1'b0;
    chk1(rirq, 1'b0);
    snd({4'h0, 8'h11});
    snd({4'h0, 8'h22});
    chk1(rrdy, 1'b0);
    acc(1'b1, 1'b1, 8'h00);
    chk(rdat, 8'h11);
    acc(1'b1, 1'b1, 8'h00);
    chk(rdat, 8'h22);
    chk1(rrdy, 1'b1);
    tend("every char and buffer");
    wreg(3'h1, 8'h60);
    tick(1);
    chk({6'h00, woe, wo}, 8'h03);
    wreg(3'h1, 8'hE0);
    tick(1);
    chk({6'h00, woe, wo}, 8'h03);
    sel = 1'b1;
    snd({4'h0, 8'h5A});
    chk1(wo, 1'b1);
    sel = 1'b0;
    tick(2);
    chk1(wo, 1'b0);
    acc(1'b1, 1'b1, 8'h00);
    chk(rdat, 8'h5A);
    wreg(3'h1, 8'hC0);
    txe = 1'b1;
    tick(2);
    chk1(wo, 1'b0);
    txe = 1'b0;
    syncm = 1'b1;
    tick(2);
    chk1(wo, 1'b1);
    crcd = 1'b1;
    tick(1);
    crcd = 1'b0;
    chk1(wo, 1'b0);
    tick(1);
    chk1(wo, 1'b1);
    tend("request");
    wreg(3'h1, 8'hA0);
    tick(1);
    chk1(woe, 1'b0);
    stall(1'b1);
    chk(rdat, 8'hC3);
    wreg(3'h1, 8'h80);
    stall(1'b0);
    tend("wait");
    wreg(3'h1, 8'h18);
    snd({4'h0, 8'h12});
    chk1(rirq, 1'b0);
    acc(1'b1, 1'b1, 8'h00);
    snd({4'h2, 8'h77});
    chk1(rirq, 1'b1);
    rreg(3'h1);
    chk(rdat, 8'h20);
    acc(1'b0, 1'b0, {2'b00, CMD_ERR_RST, 3'h0});
    tick(1);
    chk1(rirq, 1'b0);
    rreg(3'h0);
    chk(rdat & 8'h01, 8'h00);
    tend("special only");
    wreg(3'h1, 8'h1C);
    snd({4'h1, 8'h33});
    chk1(rirq, 1'b0);
    acc(1'b1, 1'b1, 8'h00);
    pen = 1'b1;
    snd({4'h1, 8'h34});
    chk1(rirq, 1'b1);
    acc(1'b0, 1'b0, {2'b00, CMD_ERR_RST, 3'h0});
    pen = 1'b0;
    tend("parity");
    wreg(3'h1, 8'h08);
    snd({4'h0, 8'h55});
    chk1(rirq, 1'b1);
    acc(1'b1, 1'b1, 8'h00);
    snd({4'h0, 8'h56});
    chk1(rirq, 1'b0);
    acc(1'b0, 1'b0, {2'b00, CMD_NEXT_RX, 3'h0});
    tick(1);
    chk1(rirq, 1'b1);
    acc(1'b1, 1'b1, 8'h00);
    chk(rdat, 8'h56);
    tend("first char");
    vector_carries_status = 1'b1;
    wreg(3'h2, 8'h00);
    wreg(3'h1, 8'h00);
    snd({4'h4, 8'h44});
    chk1(rirq, 1'b0);
    rreg(3'h2);
    chk(rdat, {4'h0, VC_SPC, 1'b0});
    vsh = 1'b1;
    rreg(3'h2);
    chk(rdat, {1'b0, VC_SPC, 4'h0});
    vsh = 1'b0;
    acc(1'b0, 1'b0, {2'b00, CMD_ERR_RST, 3'h0});
    acc(1'b1, 1'b1, 8'h00);
    wreg(3'h3, 8'h01);
    tick(1);
    snd({4'h0, 8'h00});
    acc(1'b1, 1'b1, 8'h00);
    chk(rdat, 8'hE0);
    tend("vector and length");
    wreg(3'h1, 8'h02);
    txe = 1'b1;
    tick(3);
    chk1(tirq, 1'b1);
    wreg(3'h1, 8'h01);
    ev = 7'h01;
    tick(1);
    ev = 7'h00;
    tick(2);
    chk1(eirq, 1'b1);
    smatch = 1'b1;
    tick(1);
    smatch = 1'b0;
    tick(1);
    chk1(hunt, 1'b0);
    abrt = 1'b1;
    tick(1);
    abrt = 1'b0;
    tick(1);
    chk1(hunt, 1'b1);
    smatch = 1'b1;
    tick(1);
    smatch = 1'b0;
    crst = 1'b1;
    tick(1);
    crst = 1'b0;
    tick(2);
    chk1(eirq, 1'b0);
    chk1(rxen, 1'b0);
    chk1(hunt, 1'b1);
    tend("tx and ext");
    wrap_up();
  end
endmodule : srdc_top_bench
